// File: hdl/tfs_map.vh
// Constants for the thermal fault supervisor.
`ifndef TFS_MAP_VH
`define TFS_MAP_VH
`define TFS_CLK_HZ 10000000
`define TFS_SHUTDOWN_DELAY_NS 100000
// Counts are in cycles of the 10 MHz clock, sized to the counter width.
`define TFS_SHUTDOWN_CYCLES 12'h3e8
`define TFS_WOC_OTHER_NS 10000
`define TFS_WOC_OTHER_CYCLES 12'h064
`define TFS_CNT_W 12
`define TFS_WARN_MV 640
`define TFS_HYST_MV 20
`define TFS_SHUT_MV 580
`define TFS_SOFTSTART_CYCLES 12'h3e8
`define TFS_ST_OFF 2'h0
`define TFS_ST_SOFTSTART 2'h1
`define TFS_ST_RUN 2'h2
`define TFS_ST_FAULT 2'h3
`endif

// File: hdl/tfs_supervisor.v
// Thermal fault supervisor for a dual-output regulator, with alert, counter and fault latch.
// Functional notes
// - Two identical thermal channels, core and northbridge.
// - Sense at or below warning drives alert low.
// - Counter advances during warning; terminal count 100us.
// - Counter counts down once sense recovers.
// - Warning comparison has 20mV hysteresis.
// - Alert asserted selects higher reset comparison level.
// - Alert releases only when both above reset.
// - Alert release restores the trip comparison level.
// - Sense at shutdown level declares thermal fault.
// - Fault pulls power good low, tri-states phases.
// - Fault on either output shuts both down.
// - Faults clear only by enable low or reset.
// - Enable low clears faults; enable return starts soft-start.
// - Severe overcurrent shuts down now; other within 10us.
`timescale 1ns/1ns
`include "tfs_map.vh"
module tfs_supervisor (
    // Clock and reset.
    input wire ref_clk_in,
    input wire reset_n_in,
    // Enable pin.
    input wire enable_in,
    // Comparator results, high while sense is at or below the selected level.
    input wire core_warn_cmp_in,
    input wire nb_warn_cmp_in,
    input wire core_shut_cmp_in,
    input wire nb_shut_cmp_in,
    // Severe overcurrent flags per output.
    input wire core_severe_overcurrent_in,
    input wire nb_severe_overcurrent_in,
    // Comparator level select: high selects the reset level (trip plus hysteresis).
    output reg thermal_reset_level_out,
    // Open-drain active-low alert: output is always zero, enable drives it.
    output wire thermal_alert_n_out,
    output reg thermal_alert_n_oe_out,
    // Power good open-drain and phase drive enables.
    output wire power_good_out,
    output reg power_good_oe_out,
    output reg core_phase_en_out,
    output reg nb_phase_en_out,
    // Status.
    output reg thermal_fault_out,
    output reg [1:0] state_out
);
    localparam [`TFS_CNT_W-1:0] TERM_CNT = `TFS_SHUTDOWN_CYCLES;
    localparam [`TFS_CNT_W-1:0] WOC_CNT = `TFS_WOC_OTHER_CYCLES;
    localparam [`TFS_CNT_W-1:0] SS_CNT = `TFS_SOFTSTART_CYCLES;
    // State codes of the sequencer.
    localparam [1:0] ST_OFF = `TFS_ST_OFF;
    localparam [1:0] ST_SOFTSTART = `TFS_ST_SOFTSTART;
    localparam [1:0] ST_RUN = `TFS_ST_RUN;
    localparam [1:0] ST_FAULT = `TFS_ST_FAULT;

    // =====================================================================
    // Input synchronisers.
    // =====================================================================
    // Three stages; a change is taken once stages two and three agree.
    reg [6:0] s1_reg;
    reg [6:0] s2_reg;
    reg [6:0] s3_reg;
    reg [6:0] clean_reg;
    wire [6:0] raw = {enable_in, nb_severe_overcurrent_in, core_severe_overcurrent_in,
                      nb_shut_cmp_in, core_shut_cmp_in, nb_warn_cmp_in, core_warn_cmp_in};
    integer i;
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s1_reg <= 7'h00;
            s2_reg <= 7'h00;
            s3_reg <= 7'h00;
            clean_reg <= 7'h00;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (i = 0; i < 7; i = i + 1) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    clean_reg[i] <= s3_reg[i];
                end
            end
        end
    end
    // Each flag pair holds the core channel first, then the northbridge channel.
    wire core_warn = clean_reg[0];
    wire nb_warn = clean_reg[1];
    wire any_shut = clean_reg[2] | clean_reg[3];
    wire core_woc = clean_reg[4];
    wire nb_woc = clean_reg[5];
    wire enable_ok = clean_reg[6];

    // =====================================================================
    // Alert and comparison level.
    // =====================================================================
    // The comparators see the level chosen by thermal_reset_level_out, so warn
    // flags mean "at or below trip" while released and "not above reset" while
    // asserted.
    wire any_warn = core_warn | nb_warn;
    reg alert_reg;
    reg [`TFS_CNT_W-1:0] fcnt_reg;
    reg [`TFS_CNT_W-1:0] fcnt_next;
    always @* begin
        fcnt_next = fcnt_reg;
        if (any_warn) begin
            if (fcnt_reg != TERM_CNT) begin
                fcnt_next = fcnt_reg + 1'b1;
            end
        end else if (fcnt_reg != {`TFS_CNT_W{1'b0}}) begin
            fcnt_next = fcnt_reg - 1'b1;
        end
    end

    // =====================================================================
    // Fault latch and sequencing.
    // =====================================================================
    reg [1:0] state_reg;
    reg [`TFS_CNT_W-1:0] tmr_reg;
    reg woc_pend_reg;
    reg core_on_reg;
    reg nb_on_reg;
    wire therm_trip = any_shut | (fcnt_reg == TERM_CNT);
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= ST_OFF;
            tmr_reg <= {`TFS_CNT_W{1'b0}};
            alert_reg <= 1'b0;
            fcnt_reg <= {`TFS_CNT_W{1'b0}};
            woc_pend_reg <= 1'b0;
            core_on_reg <= 1'b0;
            nb_on_reg <= 1'b0;
            thermal_fault_out <= 1'b0;
        end else if (!enable_ok) begin
            state_reg <= ST_OFF;
            tmr_reg <= {`TFS_CNT_W{1'b0}};
            alert_reg <= 1'b0;
            fcnt_reg <= {`TFS_CNT_W{1'b0}};
            woc_pend_reg <= 1'b0;
            core_on_reg <= 1'b0;
            nb_on_reg <= 1'b0;
            thermal_fault_out <= 1'b0;
        end else begin
            if (any_warn) begin
                alert_reg <= 1'b1;
            end else begin
                alert_reg <= 1'b0;
            end
            fcnt_reg <= fcnt_next;
            case (state_reg)
                ST_OFF: begin
                    state_reg <= ST_SOFTSTART;
                    tmr_reg <= {`TFS_CNT_W{1'b0}};
                end
                ST_SOFTSTART, ST_RUN: begin
                    if (state_reg == ST_SOFTSTART) begin
                        core_on_reg <= 1'b1;
                        nb_on_reg <= 1'b1;
                        tmr_reg <= tmr_reg + 1'b1;
                        if (tmr_reg == SS_CNT - 1'b1) begin
                            state_reg <= ST_RUN;
                        end
                    end
                    if (therm_trip) begin
                        state_reg <= ST_FAULT;
                        thermal_fault_out <= 1'b1;
                        core_on_reg <= 1'b0;
                        nb_on_reg <= 1'b0;
                    end else if (core_woc | nb_woc) begin
                        state_reg <= ST_FAULT;
                        core_on_reg <= core_on_reg & ~core_woc;
                        nb_on_reg <= nb_on_reg & ~nb_woc;
                        woc_pend_reg <= 1'b1;
                        tmr_reg <= {`TFS_CNT_W{1'b0}};
                    end
                end
                ST_FAULT: begin
                    if (woc_pend_reg) begin
                        tmr_reg <= tmr_reg + 1'b1;
                        if (tmr_reg >= WOC_CNT - 1'b1) begin
                            core_on_reg <= 1'b0;
                            nb_on_reg <= 1'b0;
                            woc_pend_reg <= 1'b0;
                        end
                    end else begin
                        core_on_reg <= 1'b0;
                        nb_on_reg <= 1'b0;
                    end
                    if (therm_trip) begin
                        thermal_fault_out <= 1'b1;
                        core_on_reg <= 1'b0;
                        nb_on_reg <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ST_OFF;
                end
            endcase
        end
    end

    // =====================================================================
    // Output stage.
    // =====================================================================
    assign thermal_alert_n_out = 1'b0;
    assign power_good_out = 1'b0;
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            thermal_reset_level_out <= 1'b0;
            thermal_alert_n_oe_out <= 1'b0;
            power_good_oe_out <= 1'b1;
            core_phase_en_out <= 1'b0;
            nb_phase_en_out <= 1'b0;
            state_out <= ST_OFF;
        end else begin
            thermal_reset_level_out <= alert_reg;
            thermal_alert_n_oe_out <= alert_reg;
            power_good_oe_out <= (state_reg != ST_RUN);
            core_phase_en_out <= core_on_reg;
            nb_phase_en_out <= nb_on_reg;
            state_out <= state_reg;
        end
    end
endmodule

// File: verification/tfs_host_model.sv
// Host side model that resolves the open-drain alert line.
`timescale 1ns/1ns
module tfs_host_model (
    input wire alert_data_in,
    input wire alert_oe_in,
    output wire throttle_out
);
    // The line has a pull-up, so it rests high whenever the device lets go.
    wire alert_line = alert_oe_in ? alert_data_in : 1'b1;
    assign throttle_out = !alert_line;
endmodule

// File: verification/tfs_supervisor_assertions.sv
// Port checker for the thermal fault supervisor.
`timescale 1ns/1ns
module tfs_supervisor_assertions (
    input wire ref_clk_in, reset_n_in, enable_in, core_warn_cmp_in, nb_warn_cmp_in,
    input wire core_shut_cmp_in, nb_shut_cmp_in, core_severe_overcurrent_in,
    input wire nb_severe_overcurrent_in, thermal_reset_level_out, thermal_alert_n_out,
    input wire thermal_alert_n_oe_out, power_good_out, power_good_oe_out,
    input wire core_phase_en_out, nb_phase_en_out, thermal_fault_out,
    input wire [1:0] state_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    chk_alert_sets: assert property (
        ((core_warn_cmp_in || nb_warn_cmp_in) && enable_in) [*8] |-> thermal_alert_n_oe_out)
        else $error("alert not pulled");
    chk_alert_holds: assert property (
        $fell(thermal_alert_n_oe_out) && $past(enable_in, 6)
        |-> !$past(core_warn_cmp_in, 4) && !$past(nb_warn_cmp_in, 4))
        else $error("alert released early");
    chk_level_up: assert property (
        $rose(thermal_alert_n_oe_out) |-> ##[0:2] thermal_reset_level_out)
        else $error("reset level not selected");
    chk_level_down: assert property (
        $fell(thermal_alert_n_oe_out) |-> ##[0:2] !thermal_reset_level_out)
        else $error("trip level not restored");
    chk_fault_outputs: assert property (
        $rose(thermal_fault_out)
        |-> ##[0:2] (power_good_oe_out && !core_phase_en_out && !nb_phase_en_out))
        else $error("fault outputs wrong");
    chk_shut_fault: assert property (
        $rose(core_shut_cmp_in) && enable_in && state_out == 2'h2
        |-> ##[1:10] thermal_fault_out)
        else $error("shutdown level ignored");
    chk_fault_latch: assert property (
        $fell(thermal_fault_out) |-> !$past(enable_in, 3))
        else $error("fault cleared while enabled");
    chk_woc_other: assert property (
        $rose(core_severe_overcurrent_in) && state_out == 2'h2
        |-> ##[1:8] !core_phase_en_out ##[85:110] !nb_phase_en_out)
        else $error("overcurrent shutdown late");
    chk_nb_shut_fault: assert property (
        $rose(nb_shut_cmp_in) && enable_in && state_out == 2'h2
        |-> ##[1:10] (thermal_fault_out && !core_phase_en_out))
        else $error("northbridge shutdown ignored");
    chk_nb_woc_other: assert property (
        $rose(nb_severe_overcurrent_in) && state_out == 2'h2
        |-> ##[1:8] !nb_phase_en_out ##[85:110] !core_phase_en_out)
        else $error("northbridge overcurrent shutdown late");
endmodule
bind tfs_supervisor tfs_supervisor_assertions chk (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .enable_in(enable_in), .core_warn_cmp_in(core_warn_cmp_in),
    .nb_warn_cmp_in(nb_warn_cmp_in), .core_shut_cmp_in(core_shut_cmp_in),
    .nb_shut_cmp_in(nb_shut_cmp_in), .core_severe_overcurrent_in(core_severe_overcurrent_in),
    .nb_severe_overcurrent_in(nb_severe_overcurrent_in),
    .thermal_reset_level_out(thermal_reset_level_out),
    .thermal_alert_n_out(thermal_alert_n_out), .thermal_alert_n_oe_out(thermal_alert_n_oe_out),
    .power_good_out(power_good_out), .power_good_oe_out(power_good_oe_out),
    .core_phase_en_out(core_phase_en_out), .nb_phase_en_out(nb_phase_en_out),
    .thermal_fault_out(thermal_fault_out), .state_out(state_out));

// File: verification/tfs_supervisor_bench.sv
// Self-checking bench for the thermal fault supervisor.
`timescale 1ns/1ns
module tfs_supervisor_bench;
    reg clk = 1'b0, rst_n = 1'b0, en = 1'b0, cw = 1'b0, nw = 1'b0;
    reg cs = 1'b0, ns = 1'b0, co = 1'b0, no = 1'b0;
    wire lvl, ad, aoe, pg, pgoe, cph, nph, flt, thr;
    wire [1:0] st;
    integer bad_count = 0, checked = 0;
    tfs_supervisor uut (.ref_clk_in(clk), .reset_n_in(rst_n), .enable_in(en),
        .core_warn_cmp_in(cw), .nb_warn_cmp_in(nw), .core_shut_cmp_in(cs),
        .nb_shut_cmp_in(ns), .core_severe_overcurrent_in(co),
        .nb_severe_overcurrent_in(no), .thermal_reset_level_out(lvl),
        .thermal_alert_n_out(ad), .thermal_alert_n_oe_out(aoe), .power_good_out(pg),
        .power_good_oe_out(pgoe), .core_phase_en_out(cph), .nb_phase_en_out(nph),
        .thermal_fault_out(flt), .state_out(st));
    tfs_host_model host (.alert_data_in(ad), .alert_oe_in(aoe), .throttle_out(thr));
    initial forever #50 clk = ~clk;
    task give_verdict; begin
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    end endtask
    task cmp(input logic [1:0] got, input logic [1:0] exp); begin
        checked = checked + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    end endtask
    task tick(input integer n); repeat (n) @(posedge clk); endtask
    task wait_state(input [1:0] s); integer i; begin
        for (i = 0; i < 1500 && st !== s; i = i + 1) @(posedge clk);
        if (st !== s) begin bad_count = bad_count + 1; give_verdict; end
    end endtask
    task recover; begin
        en <= 1'b0; tick(10); cmp(flt, 0);
        en <= 1'b1; wait_state(2'h1); cmp(pgoe, 1);
        wait_state(2'h2); tick(2); cmp(pgoe, 0); cmp(flt, 0);
    end endtask
    task test_startup; begin
        tick(4); rst_n <= 1'b1; en <= 1'b1;
        wait_state(2'h2); tick(2); cmp(pgoe, 0);
        cmp(pg, 0);
        cmp(aoe, 0); cmp(thr, 0);
        $display("startup test done");
    end endtask
    task test_count; begin
        cw <= 1'b1; tick(500); cw <= 1'b0; tick(300); cw <= 1'b1; tick(780);
        cmp(flt, 0);
        tick(50); cmp(flt, 1);
        cmp({cph, nph}, 2'h0); cmp(pgoe, 1);
        cw <= 1'b0; tick(50); cmp(flt, 1);
        recover;
        $display("count test done");
    end endtask
    task test_alert; begin
        cw <= 1'b1; tick(10); cmp(aoe, 1); cmp(thr, 1); cmp(lvl, 1);
        nw <= 1'b1; tick(2); cw <= 1'b0; tick(10); cmp(aoe, 1);
        nw <= 1'b0; tick(10); cmp(aoe, 0); cmp(thr, 0); cmp(lvl, 0);
        $display("alert test done");
    end endtask
    task test_shut; begin
        cs <= 1'b1; tick(10); cmp(flt, 1); cmp(st, 2'h3);
        cmp({cph, nph}, 2'h0); cmp(pgoe, 1);
        cs <= 1'b0; recover;
        $display("shutdown test done");
    end endtask
    task test_woc; begin
        co <= 1'b1; tick(10); cmp({cph, nph}, 2'h1); cmp(flt, 0);
        tick(100); cmp(nph, 0);
        co <= 1'b0; recover;
        $display("overcurrent test done");
    end endtask
    task test_nb; begin
        ns <= 1'b1; tick(10); cmp(flt, 1); cmp({cph, nph}, 2'h0); cmp(pgoe, 1);
        ns <= 1'b0; rst_n <= 1'b0; tick(4); cmp(flt, 0); cmp(pgoe, 1);
        rst_n <= 1'b1; wait_state(2'h1); wait_state(2'h2); tick(2); cmp(pgoe, 0);
        no <= 1'b1; tick(10); cmp({cph, nph}, 2'h2); cmp(flt, 0);
        tick(100); cmp(cph, 0);
        no <= 1'b0; recover;
        $display("northbridge test done");
    end endtask
    initial begin
        test_startup; test_count; test_alert; test_shut; test_woc; test_nb;
        give_verdict;
    end
endmodule
